//--- rclk_ctrl.sv
// recovered clock output control: config register, squelch decision and glitch-free gate
`timescale 1ns/1ps
`include "rclk_defs.svh"
module rclk_ctrl
  import rclk_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        SOFT_RST,
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  input  wire link_t       LINK,
  input  wire logic [2:0]  COPPER_CLK,
  input  wire logic        CLK_SQUELCH_IN,
  output logic             RECOVERED_CLOCK_OUT,
  output logic             SQUELCH_ACTIVE
);
  cfg_t        cfg_q;
  cfg_t        cfg_d;
  logic [15:0] page_q;
  logic [15:0] page_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        gate_q;
  logic        gate_d;
  logic        out_q;
  logic        out_d;
  logic [3:0]  pins_s;
  logic        ext_sq;
  logic        clk_s;
  logic        sel_ok;
  logic        link_sq;
  logic        squelch;
  logic        gp_page;
  logic [15:0] cfg_word;

  // taps and the squelch pin are asynchronous, so both pass two flops first
  rclk_sync #(.W(4)) u_sync (
    .clk  (MCLK),
    .rst  (RST),
    .ce   (CE),
    .din  ({CLK_SQUELCH_IN, COPPER_CLK}),
    .dout (pins_s)
  );

  assign ext_sq  = pins_s[3];
  assign gp_page = (page_q == `RCLK_PAGE_GP);

  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[`RCLK_EN_BIT] = cfg_q.enable;
    cfg_word[`RCLK_FREQ_HI:`RCLK_FREQ_LO] = cfg_q.freq;
    cfg_word[`RCLK_SQ_HI:`RCLK_SQ_LO] = cfg_q.level;
    cfg_word[`RCLK_SEL_HI:`RCLK_SEL_LO] = cfg_q.source;
  end

  // register port: page select at 31, config at 0x17 of the general-purpose page
  always_comb begin
    cfg_d   = cfg_q;
    page_d  = page_q;
    rdata_d = rdata_q;
    if (CE) begin
      if (SOFT_RST) begin
        page_d = `RCLK_PAGE_MAIN;
      end else if (REG_WR && REG_ADDR == `RCLK_PAGE_REG) begin
        page_d = REG_WDATA;
      end else if (REG_WR && gp_page && REG_ADDR == `RCLK_CFG_REG) begin
        cfg_d.enable = REG_WDATA[`RCLK_EN_BIT];
        cfg_d.freq   = REG_WDATA[`RCLK_FREQ_HI:`RCLK_FREQ_LO];
        cfg_d.level  = sq_level_t'(REG_WDATA[`RCLK_SQ_HI:`RCLK_SQ_LO]);
        cfg_d.source = REG_WDATA[`RCLK_SEL_HI:`RCLK_SEL_LO];
      end
      if (REG_RD) begin
        if (REG_ADDR == `RCLK_PAGE_REG) begin
          rdata_d = page_q;
        end else if (gp_page && REG_ADDR == `RCLK_CFG_REG) begin
          rdata_d = cfg_word;
        end else begin
          // unmapped addresses and the wrong page read as zero
          rdata_d = 16'h0000;
        end
      end
    end
  end

  // only the hard reset clears the settings; the soft reset leaves them alone
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cfg_q   <= '{enable: `RCLK_EN_RST, freq: `RCLK_FREQ_RST, level: SQ_AUTO, source: `RCLK_SEL_RST};
      page_q  <= `RCLK_PAGE_MAIN;
      rdata_q <= 16'h0000;
    end else begin
      cfg_q   <= cfg_d;
      page_q  <= page_d;
      rdata_q <= rdata_d;
    end
  end

  // frequency pick among the synchronised copper clock taps
  always_comb begin
    case (cfg_q.freq)
      `RCLK_FREQ_25:    clk_s = pins_s[0];
      `RCLK_FREQ_125:   clk_s = pins_s[1];
      `RCLK_FREQ_31P25: clk_s = pins_s[2];
      default:          clk_s = 1'b0;
    endcase
  end

  assign sel_ok = (cfg_q.source == `RCLK_SEL_COPPER);

  // link conditions that close the gate, per squelch level
  always_comb begin
    case (cfg_q.level)
      SQ_AUTO:  link_sq = !LINK.up || !LINK.stable || LINK.eee || (LINK.speed == `RCLK_SPEED_10)
                          || (LINK.speed == `RCLK_SPEED_1000 && LINK.master);
      SQ_RELAX: link_sq = !LINK.up || !LINK.stable || (LINK.eee && !LINK.lpi_rx);
      SQ_LINK:  link_sq = !LINK.up;
      SQ_NONE:  link_sq = 1'b0;
      default:  link_sq = 1'b1;
    endcase
  end

  // any single cause is enough to close the gate
  assign squelch = ext_sq || !cfg_q.enable || !sel_ok || link_sq;

  // gate may only change while the selected clock is low
  always_comb begin
    gate_d = gate_q;
    out_d  = out_q;
    if (CE) begin
      if (!clk_s) begin
        gate_d = squelch;
      end
      // out uses the old gate, so a pulse already under way is never cut
      out_d = clk_s && !gate_q;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      gate_q <= 1'b1;
      out_q  <= 1'b0;
    end else begin
      gate_q <= gate_d;
      out_q  <= out_d;
    end
  end

  assign REG_RDATA           = rdata_q;
  assign RECOVERED_CLOCK_OUT = out_q;
  assign SQUELCH_ACTIVE      = gate_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // every check below is cut off while the hard reset is held

  a_enable_off: assert property (CE && !cfg_q.enable && !clk_s |=> CE |=> !out_q)
    else $error("clock passed while output disabled");
  a_freq_reserved: assert property (CE && cfg_q.freq > `RCLK_FREQ_31P25 |=> !out_q)
    else $error("clock passed on reserved frequency code");
  a_freq_125: assert property (CE && !gate_q && cfg_q.freq == `RCLK_FREQ_125 |=> out_q == $past(pins_s[1]))
    else $error("125 MHz tap not selected");
  a_freq_25: assert property (CE && !gate_q && cfg_q.freq == `RCLK_FREQ_25 |=> out_q == $past(pins_s[0]))
    else $error("25 MHz tap not selected");
  a_freq_31: assert property (CE && !gate_q && cfg_q.freq == `RCLK_FREQ_31P25 |=> out_q == $past(pins_s[2]))
    else $error("31.25 MHz tap not selected");
  a_auto_master: assert property (CE && !clk_s && cfg_q.level == SQ_AUTO && LINK.master
                                  && LINK.speed == `RCLK_SPEED_1000 |=> gate_q)
    else $error("gigabit master not squelched at level 00");
  a_relax_master: assert property (CE && !clk_s && !ext_sq && cfg_q.enable && sel_ok
                                   && cfg_q.level == SQ_RELAX && LINK.up && LINK.stable && !LINK.eee |=> !gate_q)
    else $error("level 01 squelched a stable link");
  a_lpi_pass: assert property (CE && !clk_s && !ext_sq && cfg_q.enable && sel_ok
                               && cfg_q.level == SQ_RELAX && LINK.up && LINK.stable
                               && LINK.eee && LINK.lpi_rx |=> !gate_q)
    else $error("level 01 squelched low-power idle reception");
  a_link_only: assert property (CE && !clk_s && cfg_q.level == SQ_LINK && !LINK.up |=> gate_q)
    else $error("level 10 passed clock with link down");
  a_no_squelch: assert property (CE && !clk_s && !ext_sq && cfg_q.enable && sel_ok
                                 && cfg_q.level == SQ_NONE |=> !gate_q)
    else $error("level 11 squelched the clock");
  a_ext_wins: assert property (CE && !clk_s && ext_sq |=> gate_q ##1 !out_q)
    else $error("external squelch ignored");
  a_source_bad: assert property (CE && !clk_s && !sel_ok |=> gate_q)
    else $error("undefined source passed a clock");
  a_soft_keeps: assert property (CE && SOFT_RST |=> $stable(cfg_q))
    else $error("soft reset changed settings");
  a_gate_edge: assert property (CE && $past(CE) && !$past(RST) && gate_q != $past(gate_q) |-> !$past(clk_s))
    else $error("squelch changed while clock high");

  // register port and clock-enable freeze
  a_page_write: assert property (CE && !SOFT_RST && REG_WR && REG_ADDR == `RCLK_PAGE_REG
                                 |=> page_q == $past(REG_WDATA))
    else $error("page write not stored");
  a_page_read: assert property (CE && REG_RD && REG_ADDR == `RCLK_PAGE_REG |=> REG_RDATA == $past(page_q))
    else $error("page read returned wrong value");
  a_soft_page: assert property (CE && SOFT_RST |=> page_q == `RCLK_PAGE_MAIN)
    else $error("soft reset kept the page");
  a_cfg_enable: assert property (CE && !SOFT_RST && REG_WR && gp_page && REG_ADDR == `RCLK_CFG_REG
                                 |=> cfg_q.enable == $past(REG_WDATA[`RCLK_EN_BIT]))
    else $error("enable bit write not stored");
  a_state_freeze: assert property (!CE |=> $stable(cfg_q) && $stable(page_q) && $stable(rdata_q)
                                   && $stable(gate_q) && $stable(out_q))
    else $error("state moved while clock enable low");

  // scenarios worth seeing in a run
  c_pass: cover property (CE && !gate_q && out_q);
  c_ext: cover property (CE && ext_sq && gate_q);
  c_page: cover property (CE && REG_WR && gp_page && REG_ADDR == `RCLK_CFG_REG);
  c_relax_lpi: cover property (CE && cfg_q.level == SQ_RELAX && LINK.eee && LINK.lpi_rx && !gate_q);
  c_soft: cover property (CE && SOFT_RST && gp_page);
endmodule

//--- rclk_defs.svh
// offsets, field positions, reset values and page codes of the recovered clock control
`ifndef RCLK_DEFS_SVH
`define RCLK_DEFS_SVH
`define RCLK_PAGE_REG      5'h1F
`define RCLK_CFG_REG       5'h17
`define RCLK_PAGE_MAIN     16'h0000
`define RCLK_PAGE_GP       16'h0010
`define RCLK_EN_BIT        15
`define RCLK_FREQ_HI       10
`define RCLK_FREQ_LO       8
`define RCLK_SQ_HI         5
`define RCLK_SQ_LO         4
`define RCLK_SEL_HI        2
`define RCLK_SEL_LO        0
`define RCLK_EN_RST        1'h0
`define RCLK_FREQ_RST      3'h0
`define RCLK_SQ_RST        2'h0
`define RCLK_SEL_RST       3'h0
`define RCLK_FREQ_25       3'h0
`define RCLK_FREQ_125      3'h1
`define RCLK_FREQ_31P25    3'h2
`define RCLK_SEL_COPPER    3'h1
`define RCLK_SPEED_10      2'h0
`define RCLK_SPEED_100     2'h1
`define RCLK_SPEED_1000    2'h2
`endif

//--- rclk_far_end.sv
// board timing side: copper clock taps and external squelch pin
`timescale 1ns/1ps
module rclk_far_end (
  input  wire logic       clk,
  input  wire logic       squelch_cmd,
  output logic      [2:0] taps,
  output logic            squelch_pin
);
  logic [2:0] cnt = 3'h0;
  initial squelch_pin = 1'b0;
  always @(posedge clk) begin
    #1;
    cnt = cnt + 3'h1;
    squelch_pin = squelch_cmd;
  end
  // tap rates by index: middle, fastest, slowest
  assign taps = {cnt[2], cnt[0], cnt[1]};
endmodule

//--- rclk_pkg.sv
// types shared by the recovered clock output control
package rclk_pkg;
  typedef enum logic [1:0] {
    SQ_AUTO   = 2'h0,
    SQ_RELAX  = 2'h1,
    SQ_LINK   = 2'h2,
    SQ_NONE   = 2'h3
  } sq_level_t;

  typedef struct packed {
    logic       enable;
    logic [2:0] freq;
    sq_level_t  level;
    logic [2:0] source;
  } cfg_t;

  typedef struct packed {
    logic       up;
    logic       stable;
    logic [1:0] speed;
    logic       master;
    logic       eee;
    logic       lpi_rx;
  } link_t;
endpackage

//--- rclk_sync.sv
// two-stage synchroniser for levels entering from outside the clock domain
`timescale 1ns/1ps
module rclk_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = ce ? din : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

//--- recovered_clock_output_control_test.sv
// testbench for the recovered clock output control
`timescale 1ns/1ps
`include "rclk_defs.svh"
`define CHK(a,b) begin checks++; if ((a)!==(b)) begin failures++; $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module recovered_clock_output_control_test
  import rclk_pkg::*;
;
  logic        MCLK = 0, RST = 1, SOFT_RST = 0, REG_WR = 0, REG_RD = 0, CE = 1;
  logic        probe = 0, clr = 0, sq_cmd = 0, rd_p = 0, pr_p = 0, last = 0, g;
  logic [4:0]  REG_ADDR = 0;
  logic [15:0] REG_WDATA = 0, REG_RDATA, cfg, exp_v;
  logic [2:0]  COPPER_CLK;
  logic        CLK_SQUELCH_IN, RECOVERED_CLOCK_OUT, SQUELCH_ACTIVE;
  link_t       LINK = '0, lk;
  int          failures = 0, checks = 0, rises = 0;
  logic [15:0] q[$];

  always #25 MCLK = ~MCLK;

  rclk_ctrl dut_u (.MCLK(MCLK), .RST(RST), .CE(CE), .SOFT_RST(SOFT_RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LINK(LINK),
    .COPPER_CLK(COPPER_CLK), .CLK_SQUELCH_IN(CLK_SQUELCH_IN), .RECOVERED_CLOCK_OUT(RECOVERED_CLOCK_OUT),
    .SQUELCH_ACTIVE(SQUELCH_ACTIVE));
  rclk_far_end far_u (.clk(MCLK), .squelch_cmd(sq_cmd), .taps(COPPER_CLK), .squelch_pin(CLK_SQUELCH_IN));

  function automatic logic gate_exp(input logic [15:0] c, input link_t l, input logic x);
    logic hold;
    case (c[5:4])
      2'h0: hold = !l.up || !l.stable || l.eee || l.speed == `RCLK_SPEED_10
                   || (l.speed == `RCLK_SPEED_1000 && l.master);
      2'h1: hold = !l.up || !l.stable || (l.eee && !l.lpi_rx);
      2'h2: hold = !l.up;
      default: hold = 1'b0;
    endcase
    return hold || x || !c[`RCLK_EN_BIT] || c[2:0] != `RCLK_SEL_COPPER;
  endfunction

  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = w;
    REG_RD = !w;
    @(posedge MCLK);
    #1;
    REG_WR = 0;
    REG_RD = 0;
    @(posedge MCLK);
    #1;
  endtask

  // let the gate settle, then count output rises over a clean window
  task automatic check_gate(input logic [15:0] e);
    repeat (8) @(posedge MCLK);
    #1 clr = 1;
    @(posedge MCLK);
    #1 clr = 0;
    repeat (12) @(posedge MCLK);
    #1 q.push_back(e);
    probe = 1;
    @(posedge MCLK);
    #1 probe = 0;
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge MCLK) begin
    if (rd_p) begin
      exp_v = q.pop_front();
      `CHK(REG_RDATA, exp_v)
    end
    if (pr_p) begin
      exp_v = q.pop_front();
      `CHK({14'h0, SQUELCH_ACTIVE, rises != 0}, exp_v)
    end
    rises = clr ? 0 : rises + int'(RECOVERED_CLOCK_OUT && !last);
    last = RECOVERED_CLOCK_OUT;
    rd_p = REG_RD;
    pr_p = probe;
  end

  initial begin
    repeat (20000) @(posedge MCLK);
    failures++;
    close_out;
  end

  initial begin
    void'($urandom(8603));
    repeat (5) @(posedge MCLK);
    #1 RST = 0;
    check_gate(16'h0002);
    acc(1, `RCLK_CFG_REG, 16'h8111);
    acc(1, `RCLK_PAGE_REG, `RCLK_PAGE_GP);
    q.push_back(16'h0000);
    acc(0, `RCLK_CFG_REG, 16'h0);
    acc(1, `RCLK_CFG_REG, 16'hFFFF);
    q.push_back(16'h8737);
    acc(0, `RCLK_CFG_REG, 16'h0);
    q.push_back(16'h0000);
    acc(0, 5'h05, 16'h0);
    SOFT_RST = 1;
    @(posedge MCLK);
    #1 SOFT_RST = 0;
    q.push_back(16'h0000);
    acc(0, `RCLK_PAGE_REG, 16'h0);
    acc(1, `RCLK_PAGE_REG, `RCLK_PAGE_GP);
    q.push_back(16'h8737);
    acc(0, `RCLK_CFG_REG, 16'h0);
    CE = 0;
    acc(1, `RCLK_CFG_REG, 16'h0000);
    CE = 1;
    q.push_back(16'h8737);
    acc(0, `RCLK_CFG_REG, 16'h0);
    for (int i = 0; i < 48; i++) begin
      lk = link_t'(7'($urandom));
      lk.speed = 2'($urandom % 3);
      cfg = {$urandom % 4 != 0, 4'h0, 3'($urandom % 4), 2'h0, 2'($urandom), 1'b0,
             ($urandom % 4 != 0) ? `RCLK_SEL_COPPER : 3'($urandom)};
      LINK = lk;
      sq_cmd = ($urandom % 5 == 0);
      acc(1, `RCLK_CFG_REG, cfg);
      g = gate_exp(cfg, lk, sq_cmd);
      check_gate({14'h0, g, !g && cfg[10:8] <= `RCLK_FREQ_31P25});
    end
    RST = 1;
    repeat (2) @(posedge MCLK);
    #1 RST = 0;
    acc(1, `RCLK_PAGE_REG, `RCLK_PAGE_GP);
    q.push_back(16'h0000);
    acc(0, `RCLK_CFG_REG, 16'h0);
    check_gate(16'h0002);
    repeat (2) @(posedge MCLK);
    close_out;
  end
endmodule
